// >>> hw/link_pattern_self_test_defs.svh
// Offsets, field positions, reset values and codes of the link self-test
`ifndef LINK_PATTERN_SELF_TEST_DEFS_SVH
`define LINK_PATTERN_SELF_TEST_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFF_CTRL      12'h280
`define OFF_PGEN      12'h284
`define OFF_STATUS    12'h288
`define OFF_IRQ_STAT  12'h28C
`define OFF_IRQ_MASK  12'h290

// ----------------------------------------------------------------------
// Self-test control bits and reset values
// ----------------------------------------------------------------------
`define CB_LAUNCH     0
`define CB_ORIG       1
`define CB_DONE       2
`define CB_FOREVER    3
`define CB_HALT       4
`define CB_SWEEP      5
`define CTRL_W        6
`define CTRL_RESET    6'h32
`define PGEN_RESET    32'h100324C8
`define INV_RESET     14'h0001

// ----------------------------------------------------------------------
// Status layout, interrupt bits, fault states, bus answers
// ----------------------------------------------------------------------
`define ST_FAULT_LSB  16
`define IRQ_DONE      0
`define IRQ_FAULT     1
`define IRQ_W         2
`define FAULT_NONE    2'h0
`define FAULT_NOSTART 2'h1
`define FAULT_ERROR   2'h2
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define FRAMES_PER_XFER 2

`endif

// >>> hw/link_pattern_self_test_pkg.sv
// Types shared by the link self-test block
package link_pattern_self_test_pkg;

  // Pattern source control register layout
  typedef struct packed {
    logic [5:0] outerRepeatCount;
    logic [4:0] fixedLevelRepeatCount;
    logic       fixedLevelValue;
    logic [6:0] periodicRepeatCount;
    logic [2:0] periodicDivisor;
    logic [6:0] storedPatternRepeatCount;
    logic [2:0] sourceSequenceOrder;
  } pgen_ctl_t;

  // Pattern sources
  typedef enum logic [1:0] {
    SRC_STORED,
    SRC_PERIODIC,
    SRC_FIXED
  } src_t;

  // Generator sequencer states
  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_WAIT,
    GEN_RUN,
    GEN_END
  } gen_state_t;

endpackage

// >>> hw/link_pattern_self_test.sv
// Link pattern self-test engine with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "link_pattern_self_test_defs.svh"

// How it works
// - Sweep bit set keeps rotating the transmit inversion shift register.
// - Halt-on-fault stops the test at first error; else only tally.
// - Run-forever restarts the outer source sequence endlessly.
// - Run-forever writes are gated by the security permission input.
// - Sticky finished flag sets on completion; software clears by writing.
// - Originator enable lets a loopback TS1 start master operation.
// - Launch enables receiver start-delimiter search in either mode.
// - Launch plus originator starts transmission; clearing launch stops it.
// - Slave end loops back; master-master ends generate and check.
// - Outer count bits 31:26 repeat the sequence; zero sends nothing.
// - Fixed-level count bits 25:21 repeat that segment; zero disables.
// - Fixed-level source emits all zeros or all ones per value bit.
// - Periodic count bits 19:13 gives 24-bit units; zero disables.
// - Periodic divisor selects runs of one, two, three, four, six.
// - Stored count bits 9:3 replays buffer, two frames per transfer.
// - Order field picks one of six source orders; 110, 111 reserved.
// - Fault state 01 until first delimiter, 00, then 10 on error.
// - Per-lane error count of each phit adds to ten-bit tally.
module link_pattern_self_test #(
  parameter int          LANES          = 14,
  parameter int          PHIT_W         = 24,
  parameter logic [23:0] STORED_PATTERN = 24'h02CCFD
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // AXI4-Lite write channels
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Security permission
  input  wire logic                secureWriteOk,
  // Link training and receive checker
  input  wire logic                ts1Valid,
  input  wire logic                ts1Loopback,
  input  wire logic                rxStartDelim,
  input  wire logic                rxErrValid,
  input  wire logic [LANES-1:0]    rxErrLanes,
  // Transmit side
  output logic [PHIT_W-1:0]        txPhit,
  output logic                     txValid,
  output logic [LANES-1:0]         txInvert,
  output logic                     masterMode,
  output logic                     rxSearchEn,
  // Interrupt
  output logic                     irq
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Source at a slot of the chosen order; reserved codes act as 000
  function automatic link_pattern_self_test_pkg::src_t srcAt(
    input logic [2:0] order, input logic [1:0] slot);
    link_pattern_self_test_pkg::src_t s;
    s = link_pattern_self_test_pkg::SRC_STORED;
    case (order)
      3'h1:    s = (slot == 2'h0) ? link_pattern_self_test_pkg::SRC_STORED :
                   (slot == 2'h1) ? link_pattern_self_test_pkg::SRC_FIXED :
                                    link_pattern_self_test_pkg::SRC_PERIODIC;
      3'h2:    s = (slot == 2'h0) ? link_pattern_self_test_pkg::SRC_PERIODIC :
                   (slot == 2'h1) ? link_pattern_self_test_pkg::SRC_STORED :
                                    link_pattern_self_test_pkg::SRC_FIXED;
      3'h3:    s = (slot == 2'h0) ? link_pattern_self_test_pkg::SRC_PERIODIC :
                   (slot == 2'h1) ? link_pattern_self_test_pkg::SRC_FIXED :
                                    link_pattern_self_test_pkg::SRC_STORED;
      3'h4:    s = (slot == 2'h0) ? link_pattern_self_test_pkg::SRC_FIXED :
                   (slot == 2'h1) ? link_pattern_self_test_pkg::SRC_STORED :
                                    link_pattern_self_test_pkg::SRC_PERIODIC;
      3'h5:    s = (slot == 2'h0) ? link_pattern_self_test_pkg::SRC_FIXED :
                   (slot == 2'h1) ? link_pattern_self_test_pkg::SRC_PERIODIC :
                                    link_pattern_self_test_pkg::SRC_STORED;
      default: s = (slot == 2'h0) ? link_pattern_self_test_pkg::SRC_STORED :
                   (slot == 2'h1) ? link_pattern_self_test_pkg::SRC_PERIODIC :
                                    link_pattern_self_test_pkg::SRC_FIXED;
    endcase
    return s;
  endfunction

  // Phits a source emits per pass
  function automatic logic [7:0] unitsFor(
    input link_pattern_self_test_pkg::src_t s,
    input link_pattern_self_test_pkg::pgen_ctl_t c);
    logic [7:0] n;
    n = 8'h00;
    case (s)
      link_pattern_self_test_pkg::SRC_STORED:   n = 8'(c.storedPatternRepeatCount * `FRAMES_PER_XFER);
      link_pattern_self_test_pkg::SRC_PERIODIC: n = {1'b0, c.periodicRepeatCount};
      link_pattern_self_test_pkg::SRC_FIXED:    n = 8'(c.fixedLevelRepeatCount * `FRAMES_PER_XFER);
      default:                                  n = 8'h00;
    endcase
    return n;
  endfunction

  // Periodic unit, first bit sent in the MSB
  function automatic logic [23:0] periodicUnit(input logic [2:0] div);
    logic [23:0] u;
    int          k;
    u = 24'h000000;
    case (div)
      3'h2:    k = 2;
      3'h3:    k = 3;
      3'h4:    k = 4;
      3'h6:    k = 6;
      default: k = 1;
    endcase
    for (int i = 0; i < 24; i++) begin
      u[i] = (((23 - i) / k) % 2) == 1;
    end
    return u;
  endfunction

  // Number of erroring lanes in one phit
  function automatic logic [9:0] laneCount(input logic [LANES-1:0] v);
    logic [9:0] n;
    n = 10'h000;
    for (int i = 0; i < LANES; i++) begin
      n = n + 10'(v[i]);
    end
    return n;
  endfunction

  // --------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------
  logic [`CTRL_W-1:0]                   ctrl_q;
  link_pattern_self_test_pkg::pgen_ctl_t pgen_q;
  link_pattern_self_test_pkg::gen_state_t state_q;
  link_pattern_self_test_pkg::src_t     txSrc_q;
  logic [1:0]                           slot_q;
  logic [7:0]                           remain_q;
  logic                                 slotLoad_q;
  logic [5:0]                           outer_q;
  logic [LANES-1:0]                     inv_q;
  logic [1:0]                           fault_q;
  logic [9:0]                           tally_q;
  logic [`IRQ_W-1:0]                    irqStat_q;
  logic [`IRQ_W-1:0]                    irqMask_q;
  logic                                 awHave_q;
  logic                                 wHave_q;
  logic [11:0]                          awAddr_q;
  logic [31:0]                          wData_q;
  logic                                 doneSet;
  logic                                 faultSet;
  logic                                 errHit;
  logic                                 wrFire;
  logic                                 doneClr;
  logic                                 launch;

  assign launch   = ctrl_q[`CB_LAUNCH];
  assign errHit   = rxErrValid && (|rxErrLanes) &&
                    (state_q != link_pattern_self_test_pkg::GEN_IDLE);
  // Finish on halt, on the last unit, or at once for an empty run
  assign doneSet  = launch &&
                    (((state_q == link_pattern_self_test_pkg::GEN_RUN) &&
                      ((ctrl_q[`CB_HALT] && errHit) ||
                       (!slotLoad_q && remain_q <= 8'h01 &&
                        slot_q == 2'h2 && outer_q <= 6'h01 &&
                        !ctrl_q[`CB_FOREVER]))) ||
                     (state_q == link_pattern_self_test_pkg::GEN_WAIT &&
                      ts1Valid && ts1Loopback && ctrl_q[`CB_ORIG] &&
                      pgen_q.outerRepeatCount == 6'h00));
  assign faultSet = errHit && (fault_q != `FAULT_ERROR);

  // --------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------
  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_q && !s_axi_bvalid;
  assign wrFire        = awHave_q && wHave_q && !s_axi_bvalid;
  assign doneClr       = wrFire && awAddr_q == `OFF_CTRL && s_axi_wstrb[0] &&
                         wData_q[`CB_DONE];

  // Address and data capture, either order
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      awHave_q <= 1'b0;
      wHave_q  <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q  <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrFire) begin
        awHave_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
      end else if (wrFire) begin
        wHave_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_q == `OFF_CTRL || awAddr_q == `OFF_PGEN ||
                       awAddr_q == `OFF_STATUS ||
                       awAddr_q == `OFF_IRQ_STAT ||
                       awAddr_q == `OFF_IRQ_MASK) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register; finished flag set wins over clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= `CTRL_RESET;
    end else begin
      if (wrFire && awAddr_q == `OFF_CTRL && s_axi_wstrb[0]) begin
        ctrl_q[`CB_LAUNCH] <= wData_q[`CB_LAUNCH];
        ctrl_q[`CB_ORIG]   <= wData_q[`CB_ORIG];
        ctrl_q[`CB_HALT]   <= wData_q[`CB_HALT];
        ctrl_q[`CB_SWEEP]  <= wData_q[`CB_SWEEP];
        if (secureWriteOk) begin
          ctrl_q[`CB_FOREVER] <= wData_q[`CB_FOREVER];
        end
      end
      if (doneSet) begin
        ctrl_q[`CB_DONE] <= 1'b1;
      end else if (doneClr) begin
        ctrl_q[`CB_DONE] <= 1'b0;
      end
    end
  end

  // Pattern source control register, byte-lane writes
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pgen_q <= `PGEN_RESET;
    end else if (wrFire && awAddr_q == `OFF_PGEN) begin
      for (int b = 0; b < 4; b++) begin
        if (s_axi_wstrb[b]) begin
          pgen_q[b*8 +: 8] <= wData_q[b*8 +: 8];
        end
      end
    end
  end

  // Interrupt status (write one to clear, set wins) and mask
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irqStat_q <= '0;
      irqMask_q <= '0;
    end else begin
      for (int i = 0; i < `IRQ_W; i++) begin
        if ((i == `IRQ_DONE && doneSet) || (i == `IRQ_FAULT && faultSet)) begin
          irqStat_q[i] <= 1'b1;
        end else if (wrFire && awAddr_q == `OFF_IRQ_STAT &&
                     s_axi_wstrb[0] && wData_q[i]) begin
          irqStat_q[i] <= 1'b0;
        end
      end
      if (wrFire && awAddr_q == `OFF_IRQ_MASK && s_axi_wstrb[0]) begin
        irqMask_q <= wData_q[`IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // --------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Registered read data
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFF_CTRL:     s_axi_rdata <= 32'(ctrl_q);
        `OFF_PGEN:     s_axi_rdata <= pgen_q;
        `OFF_STATUS:   s_axi_rdata <= {14'h0000, fault_q, 6'h00, tally_q};
        `OFF_IRQ_STAT: s_axi_rdata <= 32'(irqStat_q);
        `OFF_IRQ_MASK: s_axi_rdata <= 32'(irqMask_q);
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Test sequencer
  // --------------------------------------------------------------------
  assign rxSearchEn = state_q != link_pattern_self_test_pkg::GEN_IDLE;

  // Launch, master entry, source walk and stop
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q    <= link_pattern_self_test_pkg::GEN_IDLE;
      masterMode <= 1'b0;
      slot_q     <= 2'h0;
      slotLoad_q <= 1'b0;
      remain_q   <= 8'h00;
      outer_q    <= 6'h00;
    end else if (!launch) begin
      state_q    <= link_pattern_self_test_pkg::GEN_IDLE;
      masterMode <= 1'b0;
    end else begin
      case (state_q)
        link_pattern_self_test_pkg::GEN_IDLE: begin
          state_q <= link_pattern_self_test_pkg::GEN_WAIT;
        end
        link_pattern_self_test_pkg::GEN_WAIT: begin
          if (ts1Valid && ts1Loopback && ctrl_q[`CB_ORIG]) begin
            masterMode <= 1'b1;
            slot_q     <= 2'h0;
            slotLoad_q <= 1'b1;
            outer_q    <= pgen_q.outerRepeatCount;
            state_q    <= (pgen_q.outerRepeatCount == 6'h00) ?
                          link_pattern_self_test_pkg::GEN_END :
                          link_pattern_self_test_pkg::GEN_RUN;
          end
        end
        link_pattern_self_test_pkg::GEN_RUN: begin
          if (doneSet) begin
            state_q <= link_pattern_self_test_pkg::GEN_END;
          end else if (slotLoad_q) begin
            slotLoad_q <= 1'b0;
            remain_q   <= unitsFor(srcAt(pgen_q.sourceSequenceOrder, slot_q),
                                   pgen_q);
          end else if (remain_q <= 8'h01) begin
            slotLoad_q <= 1'b1;
            if (slot_q == 2'h2) begin
              slot_q  <= 2'h0;
              outer_q <= ctrl_q[`CB_FOREVER] ? outer_q : outer_q - 6'h01;
            end else begin
              slot_q <= slot_q + 2'h1;
            end
          end else begin
            remain_q <= remain_q - 8'h01;
          end
        end
        link_pattern_self_test_pkg::GEN_END: begin
          state_q <= link_pattern_self_test_pkg::GEN_END;
        end
        default: state_q <= link_pattern_self_test_pkg::GEN_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Transmit datapath
  // --------------------------------------------------------------------
  // One phit per cycle while a source has units left
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txValid <= 1'b0;
      txPhit  <= '0;
      txSrc_q <= link_pattern_self_test_pkg::SRC_STORED;
    end else begin
      txValid <= launch && state_q == link_pattern_self_test_pkg::GEN_RUN &&
                 !slotLoad_q && remain_q != 8'h00 &&
                 !(ctrl_q[`CB_HALT] && errHit);
      txSrc_q <= srcAt(pgen_q.sourceSequenceOrder, slot_q);
      case (srcAt(pgen_q.sourceSequenceOrder, slot_q))
        link_pattern_self_test_pkg::SRC_PERIODIC:
          txPhit <= PHIT_W'(periodicUnit(pgen_q.periodicDivisor));
        link_pattern_self_test_pkg::SRC_FIXED:
          txPhit <= {PHIT_W{pgen_q.fixedLevelValue}};
        default: txPhit <= PHIT_W'(STORED_PATTERN);
      endcase
    end
  end

  // Inversion shift register rotates left once per cycle while enabled
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      inv_q <= `INV_RESET;
    end else if (ctrl_q[`CB_SWEEP]) begin
      inv_q <= {inv_q[LANES-2:0], inv_q[LANES-1]};
    end
  end

  assign txInvert = inv_q;

  // --------------------------------------------------------------------
  // Receive checking
  // --------------------------------------------------------------------
  // Fault state and error tally, checked in every mode
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fault_q <= `FAULT_NONE;
      tally_q <= 10'h000;
    end else begin
      if (state_q == link_pattern_self_test_pkg::GEN_IDLE && launch) begin
        fault_q <= `FAULT_NOSTART;
      end else if (faultSet) begin
        fault_q <= `FAULT_ERROR;
      end else if (rxStartDelim && fault_q == `FAULT_NOSTART) begin
        fault_q <= `FAULT_NONE;
      end
      if (rxErrValid && state_q != link_pattern_self_test_pkg::GEN_IDLE) begin
        tally_q <= tally_q + laneCount(rxErrLanes);
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_masterStart;
    state_q == link_pattern_self_test_pkg::GEN_WAIT && launch &&
    ts1Valid && ts1Loopback && ctrl_q[`CB_ORIG];
  endsequence
  sequence s_emptyRun;
    s_masterStart ##0 pgen_q.outerRepeatCount == 6'h00;
  endsequence

  a_master_entry: assert property (s_masterStart |=> masterMode)
    else $error("loopback TS1 did not enter master operation");
  a_no_master: assert property (state_q == link_pattern_self_test_pkg::GEN_WAIT
    && !ctrl_q[`CB_ORIG] && !masterMode |=> !masterMode)
    else $error("master entered with originator disabled");
  a_zero_outer: assert property (s_emptyRun |=> state_q ==
    link_pattern_self_test_pkg::GEN_END ##1 ctrl_q[`CB_DONE] && !txValid)
    else $error("zero outer count still ran the test");
  a_launch_stop: assert property (!launch |=> !txValid && !masterMode &&
    state_q == link_pattern_self_test_pkg::GEN_IDLE)
    else $error("transmitter kept running after launch cleared");
  a_sweep_rotate: assert property (ctrl_q[`CB_SWEEP] |=>
    inv_q == {$past(inv_q[LANES-2:0]), $past(inv_q[LANES-1])})
    else $error("inversion register did not rotate");
  a_halt_stop: assert property (state_q == link_pattern_self_test_pkg::GEN_RUN
    && launch && ctrl_q[`CB_HALT] && errHit |=> state_q ==
    link_pattern_self_test_pkg::GEN_END && ctrl_q[`CB_DONE])
    else $error("halt on fault did not stop the test");
  a_tally_add: assert property (rxErrValid && rxSearchEn |=>
    tally_q == 10'($past(tally_q) + laneCount($past(rxErrLanes))))
    else $error("error tally did not add the lane count");
  a_fault_first: assert property (faultSet && launch |=>
    fault_q == `FAULT_ERROR)
    else $error("first error not shown in fault state");
  a_fixed_level: assert property (txValid &&
    txSrc_q == link_pattern_self_test_pkg::SRC_FIXED |->
    txPhit == {PHIT_W{$past(pgen_q.fixedLevelValue)}})
    else $error("fixed level phit has wrong value");
  a_done_sticky: assert property (ctrl_q[`CB_DONE] && !doneClr |=>
    ctrl_q[`CB_DONE])
    else $error("finished flag dropped without a clear");
  a_forever_outer: assert property (ctrl_q[`CB_FOREVER] &&
    state_q == link_pattern_self_test_pkg::GEN_RUN |=> $stable(outer_q))
    else $error("outer count moved while running forever");

endmodule
`default_nettype wire

// >>> testbench/link_partner_model.sv
// Far-end buffer model for the link self-test
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
  // Bench request and block output
  input  wire logic core_clk,
  input  wire logic sendTs1,
  input  wire logic txValid,
  // Link towards the block
  output logic      ts1Valid,
  output logic      ts1Loopback,
  output logic      rxStartDelim,
  output logic      rxErrValid
);
  // Loopback TS1, one start delimiter, clean phits
  always_ff @(posedge core_clk) begin
    {ts1Valid, ts1Loopback} <= {sendTs1, sendTs1};
    rxStartDelim <= sendTs1 && !ts1Valid;
    rxErrValid <= txValid;
  end
endmodule
`default_nettype wire

// >>> testbench/link_pattern_self_test_bench.sv
// Link self-test bench
`timescale 1ns/100ps
`default_nettype none
module link_pattern_self_test_bench;
  logic        core_clk = 1'b0, resetn, sendTs1, irq, rxSearchEn, txValid;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ts1Valid, ts1Loopback;
  logic        rxStartDelim, rxErrValid, secOk, masterMode;
  logic [13:0] errLanes;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [1:0]  s_axi_rresp, s_axi_bresp, rrsp;
  int          bad_count = 0, checked = 0, phits = 0;
  // Block and far-end model
  link_pattern_self_test link_pattern_self_test_i (.core_clk, .resetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .secureWriteOk(secOk), .ts1Valid, .ts1Loopback, .rxStartDelim, .rxErrValid,
    .rxErrLanes(errLanes), .txPhit(), .txValid, .txInvert(), .masterMode,
    .rxSearchEn, .irq);
  link_partner_model link_partner_model_i (.core_clk, .sendTs1, .txValid,
    .ts1Valid, .ts1Loopback, .rxStartDelim, .rxErrValid);
  // Clock and phit count
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (txValid === 1'b1) phits++;
  // Compare, verdict, hang guard
  task chk(input string nm, input logic [31:0] e, g);
    checked++;
    bad_count += (g !== e);
    if (g !== e) $display("[FAIL] %s exp %h got %h", nm, e, g);
  endtask
  task final_report;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100us bad_count++;
    final_report();
  end
  // Bus write (w high) or read
  task xfer(input bit w, logic [11:0] a, logic [31:0] d);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
    {rdat, rrsp} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
  endtask
  // Test sequence
  initial begin
    {resetn, sendTs1, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {secOk, errLanes} = '0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    xfer(0, 12'h280, 0);
    chk("ctrl", 32'h32, rdat);
    xfer(0, 12'h284, 0);
    chk("pgen", 32'h100324C8, rdat);
    xfer(0, 12'h2FC, 0);
    chk("slverr", 32'h2, {30'h0, rrsp});
    xfer(1, 12'h284, 32'h04002408);
    xfer(1, 12'h290, 32'h1);
    xfer(1, 12'h280, 32'hB);
    xfer(0, 12'h288, 0);
    chk("wait", 32'h10001, {rdat[31:1], rxSearchEn});
    sendTs1 <= 1'b1;
    repeat (200) if (irq !== 1'b1) @(posedge core_clk);
    xfer(1, 12'h28C, 32'h1);
    xfer(0, 12'h280, 0);
    chk("done", 32'h6, {rdat[31:1], irq});
    chk("phits", 32'h3, phits);
    chk("master", 32'h1, {31'h0, masterMode});
    xfer(1, 12'h2FC, 0);
    chk("bresp", 32'h2, {30'h0, rrsp});
    // Halt on first fault, two lanes in error per phit
    xfer(1, 12'h280, 32'h0);
    errLanes <= 14'h0003;
    xfer(1, 12'h280, 32'h13);
    repeat (200) if (irq !== 1'b1) @(posedge core_clk);
    xfer(0, 12'h288, 0);
    chk("fault", 32'h20004, rdat);
    // Empty run with outer count zero, forever write permitted
    xfer(1, 12'h280, 32'h0);
    xfer(1, 12'h284, 32'h00002408);
    xfer(1, 12'h28C, 32'h3);
    secOk <= 1'b1;
    xfer(1, 12'h280, 32'hB);
    repeat (4) @(posedge core_clk);
    xfer(0, 12'h28C, 0);
    chk("empty", 32'h1, rdat);
    xfer(0, 12'h280, 0);
    chk("forever", 32'hF, rdat);
    final_report();
  end
endmodule
`default_nettype wire
